// ==== can_sup_pkg.sv ====
// constants, field positions and types shared by the CAN fault supervisor
// assumes a single 125 MHz clock and an AXI4-Lite register port
//
// Notes on behaviour
// [RULE1] one full recessive-dominant cycle before any detection
// [RULE2] five matching cycles identify; unidentified flag until then
// [RULE3] sample receive output at receiver low-to-high edge
// [RULE4] three consecutive wrong samples mean receive stuck recessive
// [RULE5] receive stuck: latch flag, disable bus driver
// [RULE6] receive stuck flag readable in low-power control register
// [RULE7] receive stuck: receive driver off, weak pull-down on
// [RULE8] driver off until cured, then host write re-enables
// [RULE9] transmit-low timer expiry disables driver, bus recessive
// [RULE10] transmit stuck dominant reported in timing register one
// [RULE11] transmit-to-receive short also trips transmit timeout
// [RULE12] driver off until transmit released, then host re-enables
// [RULE13] host alone decides when drivers come back; code restores bus_drv_en unaided once overtemperature and supply low end
// [RULE14] thermal or overcurrent sets flag in CAN register
// [RULE15] overtemperature disables transceiver, auto re-enables when cool
// [RULE16] second supply low turns only the transceiver off; code also clears bus_drv_en
// [RULE17] CAN register shows bus-failure and unidentified bits
// [RULE18] mismatching observation restarts qualification counters from zero
package can_sup_pkg;

  // timing
  localparam int CLK_PERIOD_NS      = 8;
  localparam int TXD_TIMEOUT_US     = 1000;
  localparam int TXD_TIMEOUT_CYCLES = (TXD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int BUS_ID_CYCLES      = 5;
  localparam int RXD_ID_SAMPLES     = 3;

  // register byte offsets
  localparam logic [7:0] CAN_REG_OFS   = 8'h00;
  localparam logic [7:0] LPC_REG_OFS   = 8'h04;
  localparam logic [7:0] TIMING_REG_ONE_REG_OFS  = 8'h08;
  localparam logic [7:0] LIVE_REG_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;

  // can register fields
  localparam int CAN_REENABLE_BIT = 0;
  localparam int CAN_UNIDENT_BIT  = 1;
  localparam int CAN_BUSFAIL_BIT  = 2;
  localparam int CAN_THERM_BIT    = 3;
  localparam int CAN_DRV_ON_BIT   = 4;
  // low-power control register fields
  localparam int LPC_RX_STUCK_RECESSIVE_FLAG_BIT     = 0;
  localparam int LPC_CANH_BIT     = 1;
  // timing register one fields
  localparam int TIMING_REG_ONE_TXD_BIT     = 0;
  localparam int TIMING_REG_ONE_CANL_BIT    = 1;
  // live status fields
  localparam int LIVE_OVERT_BIT   = 0;
  localparam int LIVE_SUPLOW_BIT  = 1;
  localparam int LIVE_XCVR_BIT    = 2;
  // interrupt event fields
  localparam int EV_BUS_ID        = 0;
  localparam int EV_RXD           = 1;
  localparam int EV_TXD           = 2;
  localparam int EV_THERM         = 3;
  localparam int EV_SUPLOW        = 4;
  localparam int EV_W             = 5;

  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  typedef enum {PH_WAIT, PH_REC, PH_DOM} bus_phase_t;

  // widen a narrow register image onto the 32-bit read bus
  function automatic logic [31:0] rd_word(input logic [7:0] v);
    rd_word = {24'h000000, v};
  endfunction : rd_word

endpackage : can_sup_pkg

// ==== qual_if.sv ====
// carrier between a fault observer and its consecutive-match qualifier
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface qual_if #(parameter int CODE_W = 3);
  logic              sample;
  logic              hit;
  logic [CODE_W-1:0] code;
  logic              done;
  logic [2:0]        count;

  modport src  (output sample, output hit, output code, input done, input count);
  modport qual (input sample, input hit, input code, output done, output count);
endinterface : qual_if

// ==== sync2.sv ====
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ns
module sync2 #(parameter int W = 1) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync2

// ==== fault_qualifier.sv ====
// counts consecutive matching fault observations up to a threshold
// assumes sample is a one-cycle pulse from the same clock domain
`timescale 1ns/1ns
module fault_qualifier #(parameter int THRESH = 5, parameter int CODE_W = 3) (
  input  wire logic aclk,
  input  wire logic aresetn,
  qual_if.qual      q
);
  logic [CODE_W-1:0] code_q;
  logic [2:0]        cnt_q;

  // clean sample or a different fault restarts the run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 3'h0;
      code_q <= '0;
    end else if (q.sample) begin
      code_q <= q.code;
      if (!q.hit) begin
        cnt_q <= 3'h0; // RULE18
      end else if (cnt_q == 3'h0 || q.code != code_q) begin
        cnt_q <= 3'h1; // RULE18
      end else if (cnt_q < 3'(THRESH)) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign q.count = cnt_q;
  assign q.done  = (cnt_q == 3'(THRESH));
endmodule : fault_qualifier

// ==== can_fault_supervisor.sv ====
// CAN transceiver fault supervisor: bus-line, receive and transmit faults
// assumes comparator and pin levels arrive asynchronously; host on AXI4-Lite
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module can_fault_supervisor
  import can_sup_pkg::*;
#(
  parameter int unsigned TXD_TIMEOUT_CYC = TXD_TIMEOUT_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_diff,
  input  wire logic        rxd_sense,
  input  wire logic        txd_in,
  input  wire logic        cmp_rec_err,
  input  wire logic        cmp_dom_canl,
  input  wire logic        cmp_dom_canh,
  input  wire logic        over_temp,
  input  wire logic        over_current,
  input  wire logic        second_supply_low,
  output logic             bus_drv_en,
  output logic             xcvr_en,
  output logic             rxd_drv_en,
  output logic             rxd_pulldown_en,
  output logic             irq
);

  // ---------------- pin synchronisation
  logic [8:0] pins_s;
  sync2 #(.W(9)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({rx_diff, rxd_sense, txd_in, cmp_rec_err, cmp_dom_canl,
               cmp_dom_canh, over_temp, over_current, second_supply_low}),
    .q       (pins_s)
  );
  logic rxdiff_s, rxd_s, txd_s, rec_s, doml_s, domh_s, ot_s, oc_s, sup_s;
  assign {rxdiff_s, rxd_s, txd_s, rec_s, doml_s, domh_s, ot_s, oc_s, sup_s} = pins_s;

  logic rxdiff_q;
  logic rxd_prev_q;
  // delayed copies for edge detection and propagation allowance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxdiff_q   <= 1'b1;
      rxd_prev_q <= 1'b0;
    end else begin
      rxdiff_q   <= rxdiff_s;
      rxd_prev_q <= rxd_s;
    end
  end
  logic rx_rise;
  logic rx_fall;
  assign rx_rise = rxdiff_s & ~rxdiff_q;
  assign rx_fall = ~rxdiff_s & rxdiff_q;

  // ---------------- recessive/dominant cycle tracking
  bus_phase_t phase_q;
  logic       rec_err_q, doml_q, domh_q;
  logic       cycle_done;
  // a cycle counts only when a recessive phase precedes the dominant one
  assign cycle_done = (phase_q == PH_DOM) && rx_rise; // RULE1

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q   <= PH_WAIT;
      rec_err_q <= 1'b0;
      doml_q    <= 1'b0;
      domh_q    <= 1'b0;
    end else begin
      case (phase_q)
        PH_WAIT: begin
          if (rxdiff_s) begin
            phase_q   <= PH_REC;
            rec_err_q <= 1'b0;
          end
        end
        PH_REC: begin
          rec_err_q <= rec_err_q | rec_s;
          if (rx_fall) begin
            phase_q <= PH_DOM;
            doml_q  <= 1'b0;
            domh_q  <= 1'b0;
          end
        end
        PH_DOM: begin
          doml_q <= doml_q | doml_s;
          domh_q <= domh_q | domh_s;
          if (rx_rise) begin
            phase_q   <= PH_REC;
            rec_err_q <= 1'b0;
          end
        end
        default: phase_q <= PH_WAIT;
      endcase
    end
  end

  // ---------------- bus-line failure qualification
  qual_if #(.CODE_W(3)) bus_q ();
  assign bus_q.sample = cycle_done;
  assign bus_q.code   = {rec_err_q, doml_q, domh_q};
  assign bus_q.hit    = rec_err_q | doml_q | domh_q;
  fault_qualifier #(.THRESH(BUS_ID_CYCLES), .CODE_W(3)) u_bus_qual (
    .aclk    (aclk),
    .aresetn (aresetn),
    .q       (bus_q)
  );

  logic unident_q, ident_q, canl_fail_q, canh_fail_q;
  // unidentified while a fault run is shorter than the threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unident_q   <= 1'b0;
      ident_q     <= 1'b0;
      canl_fail_q <= 1'b0;
      canh_fail_q <= 1'b0;
    end else begin
      unident_q <= (bus_q.count != 3'h0) && !bus_q.done; // RULE2
      ident_q   <= bus_q.done; // RULE17
      if (bus_q.done && phase_q != PH_DOM) begin
        canl_fail_q <= doml_q;
        canh_fail_q <= domh_q;
      end else if (bus_q.count == 3'h0) begin
        canl_fail_q <= 1'b0;
        canh_fail_q <= 1'b0;
      end
    end
  end

  // ---------------- receive output stuck recessive
  qual_if #(.CODE_W(1)) rxd_qi ();
  assign rxd_qi.sample = rx_rise; // RULE3
  assign rxd_qi.hit    = rxd_prev_q; // RULE3
  assign rxd_qi.code   = 1'b1;
  fault_qualifier #(.THRESH(RXD_ID_SAMPLES), .CODE_W(1)) u_rxd_qual (
    .aclk    (aclk),
    .aresetn (aresetn),
    .q       (rxd_qi)
  );

  logic rxd_fault_q;  // receive stuck, driver lock active
  logic rxd_flag_q;   // host-visible flag
  logic txd_fault_q;
  logic reenable_wr;
  logic therm_flag_q;
  logic therm_clr_wr;
  // with receive driver off the pull-down reads low once the short is gone
  logic rxd_cured, rxd_trip;
  assign rxd_cured = ~rxd_s;
  assign rxd_trip  = rxd_qi.sample && rxd_qi.hit && (rxd_qi.count >= 3'(RXD_ID_SAMPLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_fault_q <= 1'b0;
      rxd_flag_q  <= 1'b0;
    end else if (rxd_trip && !rxd_fault_q) begin
      rxd_fault_q <= 1'b1; // RULE4 RULE5
      rxd_flag_q  <= 1'b1; // RULE6
    end else if (rxd_fault_q && rxd_cured && reenable_wr) begin
      rxd_fault_q <= 1'b0; // RULE8
      rxd_flag_q  <= 1'b0;
    end
  end

  // ---------------- transmit stuck dominant timer
  logic [31:0] txd_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_cnt_q   <= 32'h00000000;
      txd_fault_q <= 1'b0;
    end else begin
      // a short to the receive output holds transmit low too, same timer
      if (txd_s) begin
        txd_cnt_q <= 32'h00000000;
      end else if (txd_cnt_q < TXD_TIMEOUT_CYC) begin
        txd_cnt_q <= txd_cnt_q + 32'h00000001; // RULE9 RULE11
      end
      if (!txd_s && txd_cnt_q == TXD_TIMEOUT_CYC - 1) begin
        txd_fault_q <= 1'b1; // RULE9
      end else if (txd_fault_q && txd_s && reenable_wr) begin
        txd_fault_q <= 1'b0; // RULE12
      end
    end
  end

  // ---------------- thermal / overcurrent flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      therm_flag_q <= 1'b0;
    end else if (ot_s || oc_s) begin
      therm_flag_q <= 1'b1; // RULE14
    end else if (therm_clr_wr) begin
      therm_flag_q <= 1'b0;
    end
  end

  // ---------------- driver and transceiver enables
  // only a host write brings the bus driver back after a latched fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_drv_en      <= 1'b0;
      xcvr_en         <= 1'b0;
      rxd_drv_en      <= 1'b0;
      rxd_pulldown_en <= 1'b0;
    end else begin
      bus_drv_en      <= ~rxd_fault_q & ~txd_fault_q & ~ot_s & ~sup_s; // RULE5 RULE9
      xcvr_en         <= ~ot_s & ~sup_s; // RULE15 RULE16
      rxd_drv_en      <= ~rxd_fault_q; // RULE7
      rxd_pulldown_en <= rxd_fault_q; // RULE7
    end
  end

  // ---------------- interrupt events
  logic [EV_W-1:0] ev_now, ev_q, irq_stat_q, irq_mask_q, stat_clr;
  assign ev_now = {sup_s, ot_s | oc_s, txd_fault_q, rxd_fault_q, ident_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_now;
    end
  end
  // set on rising event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq       <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~stat_clr) | (ev_now & ~ev_q);
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------- AXI4-Lite write channel
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic       aw_have_q, w_have_q;
  logic       do_write;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == CAN_REG_OFS || aw_addr_q == IRQ_STAT_OFS ||
                         aw_addr_q == IRQ_MASK_OFS) ? RESP_OKAY : RESP_DECERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // write-one strobes decoded from the held write
  always_comb begin
    reenable_wr  = 1'b0;
    therm_clr_wr = 1'b0;
    stat_clr     = '0;
    if (do_write && aw_addr_q == CAN_REG_OFS) begin
      reenable_wr  = w_data_q[CAN_REENABLE_BIT]; // RULE8 RULE12
      therm_clr_wr = w_data_q[CAN_THERM_BIT];
    end else if (do_write && aw_addr_q == IRQ_STAT_OFS) begin
      stat_clr = w_data_q[EV_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (do_write && aw_addr_q == IRQ_MASK_OFS) begin
      irq_mask_q <= w_data_q[EV_W-1:0];
    end
  end

  // ---------------- AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (s_axi_araddr == CAN_REG_OFS) begin
        s_axi_rdata <= rd_word({3'h0, bus_drv_en, therm_flag_q, // RULE14
                                unident_q | ident_q, unident_q, 1'b0}); // RULE17
      end else if (s_axi_araddr == LPC_REG_OFS) begin
        s_axi_rdata <= rd_word({6'h00, canh_fail_q, rxd_flag_q}); // RULE6
      end else if (s_axi_araddr == TIMING_REG_ONE_REG_OFS) begin
        s_axi_rdata <= rd_word({6'h00, canl_fail_q, txd_fault_q}); // RULE10
      end else if (s_axi_araddr == LIVE_REG_OFS) begin
        s_axi_rdata <= rd_word({5'h00, xcvr_en, sup_s, ot_s});
      end else if (s_axi_araddr == IRQ_STAT_OFS) begin
        s_axi_rdata <= rd_word({3'h0, irq_stat_q});
      end else if (s_axi_araddr == IRQ_MASK_OFS) begin
        s_axi_rdata <= rd_word({3'h0, irq_mask_q});
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rxd_done;
    rxd_trip && !rxd_fault_q;
  endsequence
  a_no_cycle_detect: assert property ((phase_q != PH_DOM) |-> !bus_q.sample) // RULE1
    else $error("bus cycle counted without dominant phase");
  a_unident_until_id: assert property (bus_q.sample && bus_q.hit && bus_q.count == 3'h0
      ##1 1'b1 |=> unident_q) // RULE2
    else $error("unidentified flag not set on first faulty cycle");
  a_id_clears_unident: assert property (bus_q.done |=> ident_q && !unident_q) // RULE17
    else $error("identified fault left unidentified flag set");
  a_rxd_needs_three: assert property ($rose(rxd_fault_q) |-> $past(rxd_qi.count) >= 3'h2
      && $past(rxd_qi.hit) && $past(rxd_qi.sample)) // RULE4
    else $error("receive fault latched before three samples");
  a_rxd_kills_drv: assert property (s_rxd_done |-> ##2 !bus_drv_en && rxd_pulldown_en
      && !rxd_drv_en) // RULE5
    else $error("receive fault did not disable drivers");
  a_rxd_stays_off: assert property (rxd_fault_q && !reenable_wr |=> rxd_fault_q) // RULE8
    else $error("receive fault cleared without host write");
  a_txd_timeout: assert property ($rose(txd_fault_q) |-> $past(txd_cnt_q) == TXD_TIMEOUT_CYC - 1
      && !$past(txd_s)) // RULE9
    else $error("transmit fault without full timeout");
  a_txd_off_hold: assert property (txd_fault_q && !txd_s |=> txd_fault_q ##1 !bus_drv_en) // RULE12
    else $error("transmit fault released while transmit low");
  a_overtemp_auto: assert property (aresetn && !ot_s && !sup_s && !rxd_fault_q && !txd_fault_q
      |=> bus_drv_en && xcvr_en) // RULE15
    else $error("transceiver not restored after fault cleared");
  a_suplow_off: assert property (sup_s |=> !xcvr_en && !bus_drv_en) // RULE16
    else $error("transceiver on during second supply low");
  a_therm_flag: assert property ((ot_s || oc_s) |=> therm_flag_q) // RULE14
    else $error("thermal or overcurrent flag not set");

endmodule : can_fault_supervisor

// ==== can_ctrl_model.sv ====
// partner model: remote nodes on the bus, receive pin and controller txd
// assumes one clock; the bench switches the pin faults on and off
`timescale 1ns/1ns
module can_ctrl_model (
  input  wire logic aclk,
  input  wire logic bus_drv_en,
  input  wire logic xcvr_en,
  input  wire logic rxd_drv_en,
  input  wire logic rxd_pulldown_en,
  input  wire logic remote_dom,
  input  wire logic txd_ctl,
  input  wire logic rxd_short_hi,
  input  wire logic txd_rxd_short,
  output logic      rx_diff,
  output logic      rxd_sense,
  output logic      txd_in
);
  logic pin_q = 1'b1;

  // wired bus: dominant when a remote node or our enabled driver pulls it
  assign rx_diff = ~(remote_dom | (bus_drv_en & xcvr_en & ~txd_in));

  // registered pin breaks the txd-rxd loop; a floating pin toggles
  always @(posedge aclk) begin
    if (rxd_short_hi) begin
      pin_q <= 1'b1;
    end else if (rxd_drv_en) begin
      pin_q <= rx_diff;
    end else if (rxd_pulldown_en) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= ~pin_q;
    end
  end

  // controller drives txd, or the shorted receive pin does
  assign rxd_sense = pin_q;
  assign txd_in    = txd_rxd_short ? pin_q : txd_ctl;
endmodule : can_ctrl_model

// ==== test_can_bus_fault_supervisor.sv ====
// self-checking bench for the CAN fault supervisor
// assumes can_ctrl_model as the far side and a shortened txd timeout
`timescale 1ns/1ns
module test_can_bus_fault_supervisor
  import can_sup_pkg::*;
;
  localparam int TMO = 20; // short txd timeout keeps the run brief
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_diff, rxd_sense, txd_in;
  logic        rec_err, dom_l, dom_h, ot, oc, sup_low, drv, xcvr, rxd_drv, pd, irq;
  logic        remote_dom, txd_ctl, short_hi, short_tr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rnd, m_stat;
  logic [1:0]  bresp, rresp, rsp;
  int          errors, total_checks, cyc;

  can_fault_supervisor #(.TXD_TIMEOUT_CYC(TMO)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_diff(rx_diff), .rxd_sense(rxd_sense), .txd_in(txd_in), .cmp_rec_err(rec_err),
    .cmp_dom_canl(dom_l), .cmp_dom_canh(dom_h), .over_temp(ot), .over_current(oc),
    .second_supply_low(sup_low), .bus_drv_en(drv), .xcvr_en(xcvr),
    .rxd_drv_en(rxd_drv), .rxd_pulldown_en(pd), .irq(irq));

  can_ctrl_model partner (
    .aclk(aclk), .bus_drv_en(drv), .xcvr_en(xcvr), .rxd_drv_en(rxd_drv),
    .rxd_pulldown_en(pd), .remote_dom(remote_dom), .txd_ctl(txd_ctl),
    .rxd_short_hi(short_hi), .txd_rxd_short(short_tr), .rx_diff(rx_diff),
    .rxd_sense(rxd_sense), .txd_in(txd_in));

  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask : cycles

  // write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
  endtask : rdreg

  // recessive then dominant, random phase length; ends recessive
  task automatic bus_cycle(input int n);
    int k;
    repeat (n) begin
      k = 4 + ($urandom % 4);
      cycles(k);
      remote_dom <= 1'b1;
      cycles(k);
      remote_dom <= 1'b0;
    end
    cycles(8);
  endtask : bus_cycle

  // compare event status with the model, then clear it
  task automatic stat_chk();
    rdreg(IRQ_STAT_OFS);
    chk(rd & 32'h1F, m_stat);
    chk(32'(irq), 32'(|m_stat));
    wr(IRQ_STAT_OFS, 32'h1F);
    m_stat = '0;
    cycles(3);
    chk(32'(irq), 32'h0);
  endtask : stat_chk

  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rec_err, dom_l, dom_h, ot, oc, sup_low, remote_dom, short_hi, short_tr} = '0;
    txd_ctl = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    m_stat = '0;
    rnd = $urandom(52833);
    cycles(10);
    aresetn <= 1'b1;
    cycles(8);
    // reset state, decode errors, mask readback
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h1E, 32'h10);
    rdreg(8'h18);
    chk({rd[29:0], rsp}, {30'h0, RESP_DECERR});
    wr(LPC_REG_OFS, 32'h1);
    chk(32'(rsp), 32'(RESP_DECERR));
    rnd = $urandom;
    wr(IRQ_MASK_OFS, rnd);
    rdreg(IRQ_MASK_OFS);
    chk(rd, {27'h0, rnd[4:0]});
    wr(IRQ_MASK_OFS, 32'h1F);
    // bus-line failure: qualification, restart on a new code
    rec_err <= 1'b1;
    cycles(8);
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h6, 32'h0);
    bus_cycle(1);
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h6, 32'h6);
    bus_cycle(2);
    dom_h <= 1'b1;
    bus_cycle(4);
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h6, 32'h6);
    bus_cycle(1);
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h6, 32'h4);
    rdreg(LPC_REG_OFS);
    chk(rd & 32'h2, 32'h2);
    {rec_err, dom_h} <= 2'b00;
    m_stat[EV_BUS_ID] = 1'b1;
    stat_chk();
    // receive pin stuck high
    short_hi <= 1'b1;
    bus_cycle(2);
    chk(32'(drv), 32'h1);
    bus_cycle(1);
    chk(32'({drv, rxd_drv, pd}), 32'h1);
    rdreg(LPC_REG_OFS);
    chk(rd & 32'h1, 32'h1);
    wr(CAN_REG_OFS, 32'h1);
    cycles(4);
    chk(32'(drv), 32'h0);
    short_hi <= 1'b0;
    cycles(4);
    wr(CAN_REG_OFS, 32'h1);
    cycles(4);
    chk(32'({drv, rxd_drv, pd}), 32'h6);
    m_stat[EV_RXD] = 1'b1;
    stat_chk();
    // transmit held dominant
    txd_ctl <= 1'b0;
    cycles(TMO - 4);
    chk(32'(drv), 32'h1);
    cycles(20);
    chk(32'({drv, rx_diff}), 32'h1);
    rdreg(TIMING_REG_ONE_REG_OFS);
    chk(rd & 32'h1, 32'h1);
    wr(CAN_REG_OFS, 32'h1);
    cycles(4);
    chk(32'(drv), 32'h0);
    txd_ctl <= 1'b1;
    cycles(40);
    chk(32'(drv), 32'h0);
    wr(CAN_REG_OFS, 32'h1);
    cycles(4);
    chk(32'(drv), 32'h1);
    m_stat[EV_TXD] = 1'b1;
    stat_chk();
    // transmit shorted to receive locks the bus after one remote bit
    short_tr <= 1'b1;
    remote_dom <= 1'b1;
    cycles(3);
    remote_dom <= 1'b0;
    cycles(8);
    chk(32'({drv, rx_diff}), 32'h2);
    cycles(TMO + 10);
    chk(32'({drv, rx_diff}), 32'h1);
    short_tr <= 1'b0;
    wr(CAN_REG_OFS, 32'h1);
    cycles(4);
    chk(32'(drv), 32'h1);
    m_stat[EV_TXD] = 1'b1;
    stat_chk();
    // thermal, overcurrent and supply low
    ot <= 1'b1;
    cycles(8);
    chk(32'({xcvr, drv}), 32'h0);
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h8, 32'h8);
    ot <= 1'b0;
    cycles(8);
    chk(32'({xcvr, drv}), 32'h3);
    wr(CAN_REG_OFS, 32'h8);
    oc <= 1'b1;
    cycles(8);
    oc <= 1'b0;
    rdreg(CAN_REG_OFS);
    chk(rd & 32'h8, 32'h8);
    sup_low <= 1'b1;
    cycles(8);
    chk(32'(xcvr), 32'h0);
    rdreg(LIVE_REG_OFS);
    chk(rd & 32'h2, 32'h2);
    sup_low <= 1'b0;
    cycles(8);
    chk(32'(xcvr), 32'h1);
    wr(IRQ_MASK_OFS, 32'h0);
    cycles(3);
    chk(32'(irq), 32'h0);
    wr(IRQ_MASK_OFS, 32'h1F);
    m_stat = (32'h1 << EV_THERM) | (32'h1 << EV_SUPLOW);
    stat_chk();
    end_sim();
  end
endmodule : test_can_bus_fault_supervisor
